// >>> rtl/local_peripheral_bus_regs.sv
// Purpose: Control and status registers of the local peripheral port.
// Assumes: Capture datapath supplies FIFO state; pins are asynchronous.
// Notes: Reads answer one cycle after the strobe; unmapped reads give zero.
//
// Local design decision: strobed register access.
`include "port_regs_map.svh"
`timescale 1ns/1ps
`default_nettype none
module local_peripheral_bus_regs #(
  parameter int SYNC_STAGES = 2,
  parameter int GPIO_LINES = 4
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic arst_n_i,
  // Register port
  input wire port_regs_pkg::reg_addr_t addr_i,
  input wire port_regs_pkg::word_t wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output port_regs_pkg::word_t rdata_o,
  // Port pins, asynchronous
  input wire logic external_port_clock_i,
  input wire logic vsync_i,
  input wire logic hsync_i,
  input wire logic serial_start_i,
  input wire logic [3:0] gpio_in_i,
  // FIFO state from the capture datapath
  input wire logic [3:0] out_fifo_level_i,
  input wire logic [2:0] out_fifo_flags_i,
  input wire logic [2:0] vid_fifo0_flags_i,
  input wire logic [2:0] vid_fifo1_flags_i,
  // Serial clock pin, open drain
  input wire logic serial_clock_pin_i,
  output logic serial_clock_pin_o,
  output logic serial_clock_pin_oe_o,
  // Controls to the datapath
  output logic port_enable_o,
  output logic store_frame_o,
  output logic byte_swap_o,
  output logic line_end_o,
  output logic frame_end_o,
  output logic add_stride_o,
  output logic load_base_o,
  output logic [21:0] load_base_addr_o,
  output port_regs_pkg::burst_t max_burst_o,
  output logic port_clk_o,
  output logic port_clk_rise_o,
  output logic [31:0] buf_addr0_o,
  output logic [31:0] buf_addr1_o,
  output logic buf_select_i_unused_o,
  output logic [20:0] direct_addr_o,
  output logic [2:0] direct_type_o,
  output logic [31:0] direct_data_o,
  output logic [3:0] gpio_out_o,
  output logic irq_o
);
  import port_regs_pkg::*;

  // The field layout assumes two synchroniser stages and four lines;
  // other values would move register fields, so they are refused.
  if (SYNC_STAGES != 2 || GPIO_LINES != 4) begin : g_param_check
    $error("unsupported synchroniser depth or line count");
  end

  ////////////////////////////////////////////////////////////////////////
  word_t mode, intr, buf0, buf1, daddr, ddata;
  logic [3:0] intr_flag, intr_en;
  logic intr_hold;
  logic [3:0] gpio_out;
  logic [1:0] s_ext_clk, s_vs, s_hs, s_ss, s_scl;
  logic [1:0] s_gi0, s_gi1, s_gi2, s_gi3;
  logic vs_d, hs_d, ss_d, clk_d, efe_d;
  logic frame_odd, first_hs;
  logic vs_ev, hs_ev, ss_ev, efe_ev, hold_low;

  function automatic logic hit(input reg_addr_t a, input reg_addr_t o);
    hit = (a == o);
  endfunction

  // Edge of the chosen polarity between the previous and present level.
  function automatic logic sync_edge(input logic now, input logic prev,
                                     input logic high);
    sync_edge = high ? (now & ~prev) : (~now & prev);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Two-stage synchronisers for every pin; only stage two is read.
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s_ext_clk <= 2'h0;
      s_vs <= 2'h0;
      s_hs <= 2'h0;
    end else begin
      s_ext_clk <= {s_ext_clk[0], external_port_clock_i};
      s_vs <= {s_vs[0], vsync_i};
      s_hs <= {s_hs[0], hsync_i};
    end
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s_ss <= 2'h0;
      s_scl <= 2'h3;
    end else begin
      s_ss <= {s_ss[0], serial_start_i};
      s_scl <= {s_scl[0], serial_clock_pin_i};
    end
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s_gi0 <= 2'h0;
      s_gi1 <= 2'h0;
      s_gi2 <= 2'h0;
      s_gi3 <= 2'h0;
    end else begin
      s_gi0 <= {s_gi0[0], gpio_in_i[0]};
      s_gi1 <= {s_gi1[0], gpio_in_i[1]};
      s_gi2 <= {s_gi2[0], gpio_in_i[2]};
      s_gi3 <= {s_gi3[0], gpio_in_i[3]};
    end
  end

  // Polarity selects which level counts as asserted sync.
  // Edges are taken on the raw level, so neither reset release nor a
  // polarity change can fake a sync event.
  assign vs_ev = sync_edge(s_vs[1], vs_d, mode[`MODE_VS_HIGH]);
  assign hs_ev = sync_edge(s_hs[1], hs_d, mode[`MODE_HS_HIGH]);
  assign ss_ev = sync_edge(s_ss[1], ss_d, 1'b1);
  assign efe_ev = sync_edge(out_fifo_flags_i[1], efe_d, 1'b1);

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      vs_d <= 1'b0;
      hs_d <= 1'b0;
      ss_d <= 1'b0;
    end else begin
      vs_d <= s_vs[1];
      hs_d <= s_hs[1];
      ss_d <= s_ss[1];
    end
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      clk_d <= 1'b0;
      efe_d <= 1'b0;
    end else begin
      clk_d <= port_clk_o;
      efe_d <= out_fifo_flags_i[1];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Port clock choice; the internal choice is a free-running toggle.
  logic int_clk;
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      int_clk <= 1'b0;
    end else begin
      int_clk <= ~int_clk;
    end
  end
  always_comb begin
    if (mode[`MODE_EXT_CLK]) begin
      port_clk_o = s_ext_clk[1] ^ mode[`MODE_INV_CLK];
    end else begin
      port_clk_o = int_clk;
    end
  end
  assign port_clk_rise_o = port_clk_o & ~clk_d;

  ////////////////////////////////////////////////////////////////////////
  // Frame skipping and stride suppression track sync edges.
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      frame_odd <= 1'b0;
      first_hs <= 1'b1;
    end else begin
      if (vs_ev) begin
        frame_odd <= mode[`MODE_ALT_FRAME] ? ~frame_odd : 1'b0;
        first_hs <= 1'b1;
      end else if (hs_ev) begin
        first_hs <= 1'b0;
      end
    end
  end
  assign store_frame_o = ~frame_odd;
  assign byte_swap_o = ~mode[`MODE_NO_SWAP];
  assign add_stride_o = hs_ev & ~(first_hs & mode[`MODE_NO_STRIDE]);
  assign line_end_o = hs_ev;
  assign frame_end_o = vs_ev;
  assign port_enable_o = mode[`MODE_ENABLE];
  assign max_burst_o = mode[`MODE_BURST_LO+1:`MODE_BURST_LO];

  ////////////////////////////////////////////////////////////////////////
  // Register writes, one register to a process; reserved bits stay zero.
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      mode <= `RESET_WORD;
    end else if (wr_i && hit(addr_i, `OFS_MODE)) begin
      mode <= wdata_i & `MODE_RW_MASK;
    end
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      buf0 <= `RESET_WORD;
    end else if (wr_i && hit(addr_i, `OFS_BUF0)) begin
      buf0 <= wdata_i & `ADDR22_MASK;
    end
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      buf1 <= `RESET_WORD;
    end else if (wr_i && hit(addr_i, `OFS_BUF1)) begin
      buf1 <= wdata_i & `ADDR22_MASK;
    end
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      daddr <= `RESET_WORD;
    end else if (wr_i && hit(addr_i, `OFS_DADDR)) begin
      daddr <= wdata_i & `DADDR_MASK;
    end
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ddata <= `RESET_WORD;
    end else if (wr_i && hit(addr_i, `OFS_DDATA)) begin
      ddata <= wdata_i;
    end
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      gpio_out <= 4'h0;
    end else if (wr_i && hit(addr_i, `OFS_GPIO)) begin
      gpio_out <= wdata_i[3:0];
    end
  end

  // Load command is a one-cycle pulse; the bit itself is never stored.
  // Buffer 0 is the current one; selection lives outside this bank.
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      load_base_o <= 1'b0;
      load_base_addr_o <= 22'h00_0000;
    end else begin
      load_base_o <= wr_i & hit(addr_i, `OFS_MODE) &
                     wdata_i[`MODE_LOAD_BASE];
      load_base_addr_o <= buf0[21:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Interrupt flags: hardware set wins over a software clear.
  logic [3:0] ev_set;
  assign ev_set = {ss_ev, vs_ev, hs_ev, efe_ev};
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      intr_flag <= 4'h0;
    end else if (wr_i && hit(addr_i, `OFS_INTR)) begin
      intr_flag <= wdata_i[3:0] | ev_set;
    end else begin
      intr_flag <= intr_flag | ev_set;
    end
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      intr_en <= 4'h0;
    end else if (wr_i && hit(addr_i, `OFS_INTR)) begin
      intr_en <= wdata_i[19:16];
    end
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      intr_hold <= 1'b0;
    end else if (wr_i && hit(addr_i, `OFS_INTR)) begin
      intr_hold <= wdata_i[`INTR_HOLD];
    end
  end

  assign intr = {7'h00, intr_hold, 4'h0, intr_en, 12'h000, intr_flag};
  assign irq_o = |(intr[3:0] & intr[19:16]);

  // Hold serial clock low once a start is seen, until software clears it.
  assign hold_low = intr[`INTR_HOLD] & intr[3];
  assign serial_clock_pin_o = 1'b0;
  assign serial_clock_pin_oe_o = hold_low;

  ////////////////////////////////////////////////////////////////////////
  // Read data, valid the cycle after the strobe.
  word_t fifo_word, next_rdata;
  assign fifo_word = {vid_fifo1_flags_i, 6'h00,
                      vid_fifo0_flags_i, 6'h00,
                      out_fifo_flags_i, 7'h00,
                      out_fifo_level_i};
  always_comb begin
    next_rdata = `RESET_WORD;
    if (hit(addr_i, `OFS_MODE)) next_rdata = mode;
    if (hit(addr_i, `OFS_FIFO)) next_rdata = fifo_word;
    if (hit(addr_i, `OFS_INTR)) next_rdata = intr;
    if (hit(addr_i, `OFS_BUF0)) next_rdata = buf0;
    if (hit(addr_i, `OFS_BUF1)) next_rdata = buf1;
    if (hit(addr_i, `OFS_DADDR)) next_rdata = daddr;
    if (hit(addr_i, `OFS_DDATA)) next_rdata = ddata;
    if (hit(addr_i, `OFS_GPIO)) begin
      next_rdata = {24'h00_0000, s_gi3[1], s_gi2[1], s_gi1[1], s_gi0[1],
                    gpio_out};
    end
  end
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rdata_o <= `RESET_WORD;
    end else if (rd_i) begin
      rdata_o <= next_rdata;
    end else begin
      rdata_o <= `RESET_WORD;
    end
  end

  assign buf_addr0_o = buf0;
  assign buf_addr1_o = buf1;
  assign buf_select_i_unused_o = s_scl[1];
  assign direct_addr_o = daddr[20:0];
  assign direct_type_o = daddr[23:21];
  assign direct_data_o = ddata;
  assign gpio_out_o = gpio_out;
endmodule
`default_nettype wire

// >>> rtl/port_regs_map.svh
// Purpose: Register offsets, field positions and reset values.
// Assumes: 16-bit byte addresses on a register port with 32-bit data words.
// Notes: Definitions only.
`ifndef PORT_REGS_MAP_SVH
`define PORT_REGS_MAP_SVH
`define OFS_MODE 16'hff00
`define OFS_FIFO 16'hff04
`define OFS_INTR 16'hff08
`define OFS_BUF0 16'hff0c
`define OFS_BUF1 16'hff10
`define OFS_DADDR 16'hff14
`define OFS_DDATA 16'hff18
`define OFS_GPIO 16'hff1c
`define MODE_ENABLE 0
`define MODE_ALT_FRAME 5
`define MODE_NO_SWAP 6
`define MODE_VS_HIGH 9
`define MODE_HS_HIGH 10
`define MODE_LOAD_BASE 13
`define MODE_BURST_LO 16
`define MODE_EXT_CLK 24
`define MODE_NO_STRIDE 25
`define MODE_INV_CLK 26
`define MODE_RW_MASK 32'h0763_067f
`define INTR_FLAG_MASK 32'h0000_000f
`define INTR_CTRL_MASK 32'h010f_0000
`define INTR_HOLD 24
`define ADDR22_MASK 32'h003f_ffff
`define DADDR_MASK 32'h00ff_ffff
`define RESET_WORD 32'h0000_0000
`endif

// >>> rtl/port_regs_pkg.sv
// Purpose: Shared types for the port register bank.
// Assumes: Nothing.
// Notes: Constants live in the map header.
package port_regs_pkg;
  typedef logic [15:0] reg_addr_t;
  typedef logic [31:0] word_t;
  typedef logic [1:0] burst_t;
endpackage

// >>> test/port_regs_chk_sva.sv
// Purpose: Port-level checks for the port register bank.
// Assumes: One clock domain with an asynchronous active-low reset.
// Notes: Bound to the top module at the foot of this file.
`timescale 1ns/1ps
`default_nettype none
module port_regs_chk (
  // Clock, reset and register port
  input wire logic sys_clk_i,
  input wire logic arst_n_i,
  input wire port_regs_pkg::reg_addr_t addr_i,
  input wire port_regs_pkg::word_t wdata_i,
  input wire logic wr_i,
  // Observed outputs
  input wire logic load_base_o,
  input wire port_regs_pkg::burst_t max_burst_o,
  input wire logic byte_swap_o,
  input wire logic [31:0] buf_addr0_o,
  input wire logic [3:0] gpio_out_o,
  input wire logic serial_clock_pin_oe_o,
  input wire logic irq_o
);
  import port_regs_pkg::*;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!arst_n_i);
  logic wr_mode;
  logic wr_intr;
  assign wr_mode = wr_i && addr_i == 16'hff00;
  assign wr_intr = wr_i && addr_i == 16'hff08;
  // The load command must never stretch into a second cycle.
  sequence load_once;
    load_base_o ##1 !load_base_o;
  endsequence
  //////////////////////////////////////////////////////////////////////////
  chk_load_pulse: assert property (
      wr_mode && wdata_i[13] |=> load_once)
    else $error("load command did not give one pulse");
  chk_load_cause: assert property (
      !(wr_mode && wdata_i[13]) |=> !load_base_o)
    else $error("load pulse without a load command");
  chk_burst_field: assert property (
      wr_mode |=> max_burst_o == $past(wdata_i[17:16]))
    else $error("burst size does not follow the mode word");
  chk_swap_bit: assert property (
      wr_mode |=> byte_swap_o == !$past(wdata_i[6]))
    else $error("byte swap does not follow the mode word");
  chk_buf0_store: assert property (wr_i && addr_i == 16'hff0c
      |=> buf_addr0_o == ($past(wdata_i) & 32'h003f_ffff))
    else $error("buffer address 0 not stored as 22 bits");
  chk_gpio_drive: assert property (wr_i && addr_i == 16'hff1c
      |=> gpio_out_o == $past(wdata_i[3:0]))
    else $error("output lines do not follow the written bits");
  chk_irq_raise: assert property (
      wr_intr && (wdata_i[3:0] & wdata_i[19:16]) != 4'h0 |=> irq_o)
    else $error("no request with a flag and its enable set");
  chk_pin_release: assert property (
      wr_intr && !wdata_i[24] |=> !serial_clock_pin_oe_o)
    else $error("serial clock pulled low without the hold bit");
endmodule
bind local_peripheral_bus_regs port_regs_chk u_chk (.sys_clk_i, .arst_n_i,
  .addr_i, .wdata_i, .wr_i, .load_base_o, .max_burst_o, .byte_swap_o,
  .buf_addr0_o, .gpio_out_o, .serial_clock_pin_oe_o, .irq_o);
`default_nettype wire

// >>> test/port_source_model.sv
// Purpose: Far-side video source driving sync, port clock and start pins.
// Assumes: Pins are asynchronous to the register clock.
// Notes: The port clock stands still between frames.
`timescale 1ns/1ps
`default_nettype none
module port_source_model (
  // Port pins
  output logic ext_clk_o,
  output logic hsync_o,
  output logic vsync_o,
  output logic start_o
);
  initial begin
    ext_clk_o = 1'b0;
    hsync_o = 1'b0;
    vsync_o = 1'b0;
    start_o = 1'b0;
  end
  //////////////////////////////////////////////////////////////////////////
  // One frame of two lines; pol is the asserted level of both syncs.
  task automatic frame(input logic pol);
    hsync_o = !pol;
    vsync_o = !pol;
    #200;
    vsync_o = pol;
    #80;
    vsync_o = !pol;
    repeat (2) begin
      repeat (8) #40 ext_clk_o = !ext_clk_o;
      hsync_o = pol;
      #80;
      hsync_o = !pol;
    end
    #200;
  endtask
  task automatic start_cond();
    start_o = 1'b1;
    #80;
    start_o = 1'b0;
    #200;
  endtask
endmodule
`default_nettype wire

// >>> test/local_peripheral_bus_regs_bench.sv
// Purpose: Self-checking bench for the port register bank.
// Assumes: Registers reached by one-cycle strobes; read data a cycle later.
// Notes: Sync and start events come from the source model.
`timescale 1ns/1ps
`default_nettype none
module local_peripheral_bus_regs_bench;
  import port_regs_pkg::*;
  logic sys_clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  reg_addr_t addr_i = 16'h0000;
  word_t wdata_i = 32'h0000_0000;
  word_t rdata_o;
  logic [3:0] out_fifo_level_i = 4'h9;
  logic [3:0] gpio_in_i = 4'ha;
  logic [2:0] out_fifo_flags_i = 3'b101;
  logic [2:0] vid_fifo0_flags_i = 3'b010;
  logic [2:0] vid_fifo1_flags_i = 3'b110;
  logic ext_clk, vs, hs, st, pin_o, pin_oe, pin;
  logic store_frame_o, byte_swap_o, port_clk_o, irq_o, s0;
  burst_t max_burst_o;
  logic [3:0] gpio_out_o;
  logic line_end, frame_end, add_stride, port_en;
  logic [31:0] buf1_seen, ddata_seen;
  logic [20:0] daddr_seen;
  logic [2:0] dtype_seen;
  int n_line = 0;
  int n_frame = 0;
  int n_stride = 0;
  int errors = 0;
  int n_checks = 0;
  word_t msk[5] = '{32'h003f_ffff, 32'h003f_ffff, 32'h00ff_ffff,
                    32'hffff_ffff, 32'h0000_00af};
  // The pin has a pull-up, so a released line reads high.
  assign pin = pin_oe ? pin_o : 1'b1;
  always #5 sys_clk_i = !sys_clk_i;
  // Pulses are counted at the falling edge, where they are settled.
  always @(negedge sys_clk_i) begin
    if (line_end) n_line++;
    if (frame_end) n_frame++;
    if (add_stride) n_stride++;
  end
  port_source_model src (.ext_clk_o(ext_clk), .hsync_o(hs), .vsync_o(vs),
    .start_o(st));
  local_peripheral_bus_regs dut (.sys_clk_i, .arst_n_i, .addr_i, .wdata_i,
    .wr_i, .rd_i, .rdata_o, .external_port_clock_i(ext_clk), .vsync_i(vs),
    .hsync_i(hs), .serial_start_i(st), .gpio_in_i, .out_fifo_level_i,
    .out_fifo_flags_i, .vid_fifo0_flags_i, .vid_fifo1_flags_i,
    .serial_clock_pin_i(pin), .serial_clock_pin_o(pin_o),
    .serial_clock_pin_oe_o(pin_oe), .port_enable_o(port_en), .store_frame_o,
    .byte_swap_o, .line_end_o(line_end), .frame_end_o(frame_end),
    .add_stride_o(add_stride), .load_base_o(), .load_base_addr_o(),
    .max_burst_o, .port_clk_o, .port_clk_rise_o(), .buf_addr0_o(),
    .buf_addr1_o(buf1_seen), .buf_select_i_unused_o(),
    .direct_addr_o(daddr_seen), .direct_type_o(dtype_seen),
    .direct_data_o(ddata_seen), .gpio_out_o, .irq_o);
  //////////////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input word_t s, input word_t e);
    n_checks++;
    if (s !== e) begin
      errors++;
      $display("FAIL %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input reg_addr_t a, input word_t d);
    @(posedge sys_clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge sys_clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input reg_addr_t a, input word_t e, input string n);
    @(posedge sys_clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge sys_clk_i);
    rd_i <= 1'b0;
    #1 chk(n, rdata_o, e);
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial begin
    #100000;
    errors++;
    finish_test();
  end
  initial begin
    repeat (4) @(posedge sys_clk_i);
    arst_n_i <= 1'b1;
    rd(16'hff00, 32'h0000_0000, "mode reset");
    chk("swap reset", 32'(byte_swap_o), 32'h0000_0001);
    $display("test reset done");
    wr(16'hff00, 32'hffff_ffff);
    rd(16'hff00, 32'h0763_067f, "mode bits");
    chk("swap", 32'(byte_swap_o), 32'h0000_0000);
    chk("burst", 32'(max_burst_o), 32'h0000_0003);
    chk("port clock inverted", 32'(port_clk_o), 32'h0000_0001);
    wr(16'hff00, 32'h0100_0000);
    repeat (3) @(posedge sys_clk_i);
    #1 chk("port clock", 32'(port_clk_o), 32'h0000_0000);
    $display("test mode done");
    wr(16'hff04, 32'hffff_ffff);
    rd(16'hff04, 32'hc020_2809, "fifo status");
    for (int i = 0; i < 5; i++) begin
      wr(16'hff0c + 16'(4 * i), 32'hffff_ffff);
      rd(16'hff0c + 16'(4 * i), msk[i], "data register");
    end
    chk("gpio out", 32'(gpio_out_o), 32'h0000_000f);
    chk("buffer 1 out", buf1_seen, 32'h003f_ffff);
    chk("direct address", 32'(daddr_seen), 32'h001f_ffff);
    chk("direct type", 32'(dtype_seen), 32'h0000_0007);
    chk("direct data", ddata_seen, 32'hffff_ffff);
    wr(16'hff20, 32'hffff_ffff);
    rd(16'hff20, 32'h0000_0000, "unmapped");
    $display("test registers done");
    wr(16'hff00, 32'h0000_0621);
    wr(16'hff08, 32'h010f_0000);
    s0 = store_frame_o;
    src.frame(1'b1);
    rd(16'hff08, 32'h010f_0006, "sync flags");
    chk("irq sync", 32'(irq_o), 32'h0000_0001);
    chk("skip frame", 32'(store_frame_o), 32'(!s0));
    chk("port enable", 32'(port_en), 32'h0000_0001);
    chk("line ends", 32'(n_line), 32'h0000_0002);
    chk("frame ends", 32'(n_frame), 32'h0000_0001);
    chk("stride adds", 32'(n_stride), 32'h0000_0002);
    src.start_cond();
    rd(16'hff08, 32'h010f_000e, "start flag");
    chk("pin held", 32'(pin), 32'h0000_0000);
    wr(16'hff08, 32'h0000_0000);
    rd(16'hff08, 32'h0000_0000, "flags cleared");
    chk("pin free", 32'(pin), 32'h0000_0001);
    chk("irq clear", 32'(irq_o), 32'h0000_0000);
    wr(16'hff00, 32'h0200_0621);
    src.frame(1'b1);
    chk("store frame", 32'(store_frame_o), 32'(s0));
    chk("line ends 2", 32'(n_line), 32'h0000_0004);
    chk("stride first line", 32'(n_stride), 32'h0000_0003);
    $display("test events done");
    wr(16'hff08, 32'h0001_0000);
    @(posedge sys_clk_i);
    out_fifo_flags_i <= 3'b111;
    repeat (4) @(posedge sys_clk_i);
    rd(16'hff08, 32'h0001_0001, "empty flag");
    chk("irq empty", 32'(irq_o), 32'h0000_0001);
    wr(16'hff08, 32'h0004_0004);
    #1 chk("irq frame", 32'(irq_o), 32'h0000_0001);
    $display("test interrupts done");
    finish_test();
  end
endmodule
`default_nettype wire
